// [rtl/tmc_timer16.sv]
// Purpose: Control and configuration of a 16-bit timer/counter behind APB.
// Assumes: pclk is the fast system clock; ext_trigger and fs_tick are synchronous.
// Notes:   Detailed per-mode counting, interrupts and divider output live elsewhere.
//
// What this block does
// - The mode field picks timer, window, pulse-width or pulse-output operation.
// - The source field picks fc/2^11 (or fs/2^3), fc/2^7 or fc/2^3 as count clock.
// - A timer register takes its new value at the first source tick after a high write.
// - A low-byte write alone leaves the effective value unchanged.
// - Entering stop mode clears the start field to 00 by hardware.
// - The count is captured on each source tick while capture is on and running, except in pulse-output mode.
// - The second register accepts writes only in pulse-output mode.
//
// Design decisions made here: the APB slave port and the address map.

`timescale 1ns/1ps

module tmc_timer16 (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_trigger,
    input  wire logic        fs_tick,
    output logic             timer_running,
    output logic [1:0]       operating_mode_field
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0]          timer1_control_q;
    logic [7:0]          timer1_control_d;
    logic [2:0]          sys_ctrl_q;
    logic [2:0]          sys_ctrl_d;
    logic [31:0]         prdata_q;
    logic [31:0]         prdata_d;
    logic [15:0]         count_q;
    logic [15:0]         count_d;
    logic                ext_prev_q;
    logic                ext_prev_d;
    tmc_pkg::tmc_run_e   run_q;
    tmc_pkg::tmc_run_e   run_d;

    logic                setup_rd;
    logic                wr_acc;
    logic [9:0]          idx;
    logic                mapped;
    logic                wr_first_lo;
    logic                wr_first_hi;
    logic                wr_second_lo;
    logic                wr_second_hi;
    logic                stop_enter;
    logic                src_tick;
    logic                running;
    logic                cap_en;
    logic                ext_rise;
    logic                ext_fall;
    logic [15:0]         first_val;
    logic [15:0]         second_val;

    logic [1:0]          mode_f;
    logic [1:0]          clk_f;
    logic [1:0]          start_f;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign idx      = paddr[11:2];
    assign setup_rd = psel & ~penable & ~pwrite;
    assign wr_acc   = psel & penable & pwrite;

    always_comb begin
        case (idx)
            tmc_pkg::IDX_FIRST_LO,
            tmc_pkg::IDX_FIRST_HI,
            tmc_pkg::IDX_SECOND_LO,
            tmc_pkg::IDX_SECOND_HI,
            tmc_pkg::IDX_CONTROL,
            tmc_pkg::IDX_SYS_CTRL,
            tmc_pkg::IDX_STATUS:   mapped = 1'b1;
            default:               mapped = 1'b0;
        endcase
    end

    assign mode_f  = timer1_control_q[tmc_pkg::MODE_LSB +: 2];
    assign clk_f   = timer1_control_q[tmc_pkg::CLK_LSB +: 2];
    assign start_f = timer1_control_q[tmc_pkg::START_LSB +: 2];

    assign wr_first_lo  = wr_acc & (idx == tmc_pkg::IDX_FIRST_LO);
    assign wr_first_hi  = wr_acc & (idx == tmc_pkg::IDX_FIRST_HI);

    assign wr_second_lo = wr_acc & (idx == tmc_pkg::IDX_SECOND_LO)
                        & (mode_f == tmc_pkg::MODE_PULSE_OUT);
    assign wr_second_hi = wr_acc & (idx == tmc_pkg::IDX_SECOND_HI)
                        & (mode_f == tmc_pkg::MODE_PULSE_OUT);

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    assign stop_enter = wr_acc & (idx == tmc_pkg::IDX_SYS_CTRL)
                      & pwdata[tmc_pkg::SYS_STOP_BIT] & ~sys_ctrl_q[tmc_pkg::SYS_STOP_BIT];

    always_comb begin
        timer1_control_d = timer1_control_q;
        sys_ctrl_d       = sys_ctrl_q;
        if (wr_acc && (idx == tmc_pkg::IDX_CONTROL)) begin
            timer1_control_d = pwdata[7:0];
        end
        if (wr_acc && (idx == tmc_pkg::IDX_SYS_CTRL)) begin
            sys_ctrl_d = pwdata[2:0];
        end
        // Stop entry overrides a control write landing in the same cycle.
        // hardware clears start
        if (stop_enter) begin
            timer1_control_d[tmc_pkg::START_LSB +: 2] = tmc_pkg::START_STOP;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer1_control_q <= tmc_pkg::CONTROL_RESET;
            sys_ctrl_q       <= tmc_pkg::SYS_RESET;
        end else begin
            timer1_control_q <= timer1_control_d;
            sys_ctrl_q       <= sys_ctrl_d;
        end
    end

    // ------------------------------------------------------------
    // Count source
    // ------------------------------------------------------------
    tmc_source_tick u_tick (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_sel   (clk_f),
        .div_alt   (sys_ctrl_q[tmc_pkg::SYS_DIVALT_BIT]),
        .slow_mode (sys_ctrl_q[tmc_pkg::SYS_SLOW_BIT]),
        .fs_tick   (fs_tick),
        .src_tick  (src_tick)
    );

    // ------------------------------------------------------------
    // Start control
    // ------------------------------------------------------------
    assign ext_rise = ext_trigger & ~ext_prev_q;
    assign ext_fall = ~ext_trigger & ext_prev_q;
    assign running  = (run_q == tmc_pkg::TMC_RUN);

    always_comb begin
        ext_prev_d = ext_trigger;
        run_d      = run_q;
        case (run_q)
            tmc_pkg::TMC_IDLE: begin
                if (start_f == tmc_pkg::START_CMD) begin
                    run_d = tmc_pkg::TMC_RUN;
                end else if (start_f != tmc_pkg::START_STOP) begin
                    run_d = tmc_pkg::TMC_ARMED;
                end
            end
            tmc_pkg::TMC_ARMED: begin
                if (start_f == tmc_pkg::START_STOP) begin
                    run_d = tmc_pkg::TMC_IDLE;
                end else if (start_f == tmc_pkg::START_CMD) begin
                    run_d = tmc_pkg::TMC_RUN;
                end else if ((start_f == tmc_pkg::START_RISE && ext_rise) ||
                             (start_f == tmc_pkg::START_FALL && ext_fall)) begin
                    run_d = tmc_pkg::TMC_RUN;
                end
            end
            tmc_pkg::TMC_RUN: begin
                if (start_f == tmc_pkg::START_STOP) begin
                    run_d = tmc_pkg::TMC_IDLE;
                end
            end
            default: begin
                run_d = tmc_pkg::TMC_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q      <= tmc_pkg::TMC_IDLE;
            ext_prev_q <= 1'b0;
        end else begin
            run_q      <= run_d;
            ext_prev_q <= ext_prev_d;
        end
    end

    // ------------------------------------------------------------
    // Up-counter
    // ------------------------------------------------------------
    always_comb begin
        count_d = count_q;
        if (start_f == tmc_pkg::START_STOP) begin
            count_d = 16'h0000;
        end else if (running && src_tick) begin
            // Matching the first register restarts the count from zero.
            if (count_q == first_val) begin
                count_d = 16'h0000;
            end else begin
                count_d = count_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 16'h0000;
        end else begin
            count_q <= count_d;
        end
    end

    // ------------------------------------------------------------
    // Timer registers
    // ------------------------------------------------------------
    tmc_timer_reg u_first (
        .pclk     (pclk),
        .presetn  (presetn),
        .wr_lo    (wr_first_lo),
        .wr_hi    (wr_first_hi),
        .wdata    (pwdata[7:0]),
        .src_tick (src_tick),
        .cap_en   (1'b0),
        .cap_val  (16'h0000),
        .value    (first_val)
    );

    // The capture bit doubles as the repeat control in pulse-output mode,
    // so capture is honoured only in the modes that can use it.
    // capture on source tick
    assign cap_en = timer1_control_q[tmc_pkg::CAP_BIT] & running
                  & (mode_f != tmc_pkg::MODE_PULSE_OUT);

    tmc_timer_reg u_second (
        .pclk     (pclk),
        .presetn  (presetn),
        .wr_lo    (wr_second_lo),
        .wr_hi    (wr_second_hi),
        .wdata    (pwdata[7:0]),
        .src_tick (src_tick),
        .cap_en   (cap_en),
        .cap_val  (count_q),
        .value    (second_val)
    );

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        prdata_d = prdata_q;
        if (setup_rd) begin
            case (idx)
                tmc_pkg::IDX_FIRST_LO:  prdata_d = {24'h000000, first_val[7:0]};
                tmc_pkg::IDX_FIRST_HI:  prdata_d = {24'h000000, first_val[15:8]};
                tmc_pkg::IDX_SECOND_LO: prdata_d = {24'h000000, second_val[7:0]};
                tmc_pkg::IDX_SECOND_HI: prdata_d = {24'h000000, second_val[15:8]};
                tmc_pkg::IDX_CONTROL:   prdata_d = {24'h000000, timer1_control_q};
                tmc_pkg::IDX_SYS_CTRL:  prdata_d = {29'h0, sys_ctrl_q};
                tmc_pkg::IDX_STATUS:    prdata_d = {15'h0000, running, count_q};
                default:                prdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Read data is latched in the setup cycle, so the access phase never waits.
    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    assign operating_mode_field = mode_f;
    assign timer_running        = running;

endmodule

// [rtl/tmc_pkg.sv]
// Purpose: Shared constants for the 16-bit timer control and configuration block.
// Assumes: APB slave with 32-bit data and one aligned word per register.
// Notes:   The byte address of each register is four times its index.

package tmc_pkg;

    // ------------------------------------------------------------
    // Register indices and address width
    // ------------------------------------------------------------
    localparam logic [9:0]  IDX_FIRST_LO   = 10'h010;
    localparam logic [9:0]  IDX_FIRST_HI   = 10'h011;
    localparam logic [9:0]  IDX_SECOND_LO  = 10'h012;
    localparam logic [9:0]  IDX_SECOND_HI  = 10'h013;
    localparam logic [9:0]  IDX_CONTROL    = 10'h026;
    localparam logic [9:0]  IDX_SYS_CTRL   = 10'h027;
    localparam logic [9:0]  IDX_STATUS     = 10'h028;
    localparam int          ADDR_W         = 12;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int          MODE_LSB       = 0;
    localparam int          CLK_LSB        = 2;
    localparam int          START_LSB      = 4;
    localparam int          CAP_BIT        = 6;
    localparam int          TFF_BIT        = 7;
    localparam logic [7:0]  CONTROL_RESET  = 8'h00;

    // System control fields.
    localparam int          SYS_DIVALT_BIT = 0;
    localparam int          SYS_SLOW_BIT   = 1;
    localparam int          SYS_STOP_BIT   = 2;
    localparam logic [2:0]  SYS_RESET      = 3'h0;

    // Status fields.
    localparam int          STAT_RUN_BIT   = 16;

    localparam logic [15:0] TREG_RESET     = 16'hffff;

    // ------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------
    localparam logic [1:0]  MODE_TIMER     = 2'h0;
    localparam logic [1:0]  MODE_WINDOW    = 2'h1;
    localparam logic [1:0]  MODE_PULSE_W   = 2'h2;
    localparam logic [1:0]  MODE_PULSE_OUT = 2'h3;

    localparam logic [1:0]  START_STOP     = 2'h0;
    localparam logic [1:0]  START_CMD      = 2'h1;
    localparam logic [1:0]  START_RISE     = 2'h2;
    localparam logic [1:0]  START_FALL     = 2'h3;

    localparam logic [1:0]  CLK_SLOWEST    = 2'h0;
    localparam logic [1:0]  CLK_MID        = 2'h1;
    localparam logic [1:0]  CLK_FAST       = 2'h2;

    // ------------------------------------------------------------
    // Divider exponents
    // ------------------------------------------------------------
    localparam int          FC_SHIFT_SLOW  = 11;
    localparam int          FC_SHIFT_MID   = 7;
    localparam int          FC_SHIFT_FAST  = 3;
    localparam int          FS_SHIFT       = 3;

    typedef enum logic [2:0] {
        TMC_IDLE  = 3'b001,
        TMC_ARMED = 3'b010,
        TMC_RUN   = 3'b100
    } tmc_run_e;

endpackage

// [rtl/tmc_source_tick.sv]
// Purpose: Count-source tick generator from the fast and the slow clock.
// Assumes: fs_tick is a one-cycle pulse at the low-frequency clock rate.
// Notes:   The selected source appears as a one-cycle pulse on src_tick.

`timescale 1ns/1ps

module tmc_source_tick (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] clk_sel,
    input  wire logic       div_alt,
    input  wire logic       slow_mode,
    input  wire logic       fs_tick,
    output logic            src_tick
);

    logic [10:0] fc_cnt_q;
    logic [10:0] fc_cnt_d;
    logic [2:0]  fs_cnt_q;
    logic [2:0]  fs_cnt_d;
    logic        tick_q;
    logic        tick_d;
    logic        fc_slow;
    logic        fc_mid;
    logic        fc_fast;
    logic        fs_div;

    // ------------------------------------------------------------
    // Dividers and selection
    // ------------------------------------------------------------
    always_comb begin
        fc_cnt_d = fc_cnt_q + 11'h001;
        fs_cnt_d = fs_tick ? fs_cnt_q + 3'h1 : fs_cnt_q;
        fc_slow  = &fc_cnt_q[tmc_pkg::FC_SHIFT_SLOW-1:0];
        fc_mid   = &fc_cnt_q[tmc_pkg::FC_SHIFT_MID-1:0];
        fc_fast  = &fc_cnt_q[tmc_pkg::FC_SHIFT_FAST-1:0];
        fs_div   = fs_tick & (&fs_cnt_q[tmc_pkg::FS_SHIFT-1:0]);
        case (clk_sel)
            tmc_pkg::CLK_SLOWEST: tick_d = (div_alt | slow_mode) ? fs_div : fc_slow;
            tmc_pkg::CLK_MID:     tick_d = slow_mode ? 1'b0 : fc_mid;
            tmc_pkg::CLK_FAST:    tick_d = slow_mode ? 1'b0 : fc_fast;
            default:              tick_d = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fc_cnt_q <= 11'h000;
            fs_cnt_q <= 3'h0;
            tick_q   <= 1'b0;
        end else begin
            fc_cnt_q <= fc_cnt_d;
            fs_cnt_q <= fs_cnt_d;
            tick_q   <= tick_d;
        end
    end

    assign src_tick = tick_q;

endmodule

// [rtl/tmc_timer_reg.sv]
// Purpose: One 16-bit timer register with a staged byte load.
// Assumes: Byte writes arrive as one-cycle strobes with their data.
// Notes:   The effective value changes only on a count-source tick.

`timescale 1ns/1ps

module tmc_timer_reg (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        wr_lo,
    input  wire logic        wr_hi,
    input  wire logic [7:0]  wdata,
    input  wire logic        src_tick,
    input  wire logic        cap_en,
    input  wire logic [15:0] cap_val,
    output logic [15:0]      value
);

    logic [7:0]  lo_q;
    logic [7:0]  lo_d;
    logic [7:0]  hi_q;
    logic [7:0]  hi_d;
    logic        pend_q;
    logic        pend_d;
    logic [15:0] val_q;
    logic [15:0] val_d;

    // ------------------------------------------------------------
    // Staging and transfer
    // ------------------------------------------------------------
    always_comb begin
        lo_d   = wr_lo ? wdata : lo_q;
        hi_d   = wr_hi ? wdata : hi_q;
        pend_d = pend_q;
        val_d  = val_q;
        if (src_tick && cap_en) begin
            val_d = cap_val;
        end else if (src_tick && pend_q) begin
            val_d  = {hi_q, lo_q};
            pend_d = 1'b0;
        end
        // A high write landing with the tick keeps the update pending.
        if (wr_hi) begin
            pend_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lo_q   <= tmc_pkg::TREG_RESET[7:0];
            hi_q   <= tmc_pkg::TREG_RESET[15:8];
            pend_q <= 1'b0;
            val_q  <= tmc_pkg::TREG_RESET;
        end else begin
            lo_q   <= lo_d;
            hi_q   <= hi_d;
            pend_q <= pend_d;
            val_q  <= val_d;
        end
    end

    assign value = val_q;

endmodule

// [tb/tmc_timer16_sva.sv]
// Purpose: Port-level assertions for the timer control block.
// Assumes: One pclk domain with presetn active low.
// Notes:   Stop entry is tracked from bus writes to the system control word.
`timescale 1ns/1ps
module tmc_timer16_chk (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        timer_running,
    input  wire logic [1:0]  operating_mode_field
);
    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    logic acc;
    logic ctl_wr;
    logic sys_wr;
    logic kill;
    logic stop_d;
    logic stop_q;
    assign acc    = psel && penable;
    assign ctl_wr = acc && pwrite && paddr[11:2] == tmc_pkg::IDX_CONTROL;
    assign sys_wr = acc && pwrite && paddr[11:2] == tmc_pkg::IDX_SYS_CTRL;
    // A stop-mode write only counts as entry when the bit was clear before.
    assign kill   = (ctl_wr && pwdata[5:4] == tmc_pkg::START_STOP)
                  || (sys_wr && pwdata[2] && !stop_q);
    always_comb begin
        stop_d = stop_q;
        if (sys_wr) begin
            stop_d = pwdata[2];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_q <= 1'b0;
        end else begin
            stop_q <= stop_d;
        end
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_mode_follows: assert property (ctl_wr |=> operating_mode_field == $past(pwdata[1:0]))
        else $error("mode field differs from written code");
    a_mode_holds: assert property (!ctl_wr |=> $stable(operating_mode_field))
        else $error("mode field moved without a control write");
    a_cmd_start: assert property (ctl_wr && pwdata[5:4] == tmc_pkg::START_CMD && !stop_q
        |-> ##[1:2] timer_running) else $error("command start did not run");
    a_stop_code: assert property (ctl_wr && pwdata[5:4] == tmc_pkg::START_STOP
        |-> ##[1:2] !timer_running) else $error("stop code left timer running");
    a_stop_entry: assert property (sys_wr && pwdata[2] && !stop_q
        |-> ##[1:2] !timer_running) else $error("stop mode entry left timer running");
    a_run_holds: assert property (timer_running && !kill && !$past(kill) |=> timer_running)
        else $error("timer left run state without a stop");
    a_map_ok: assert property (acc && paddr[11:2] inside {[10'h010:10'h013]}
        |-> !pslverr && pready) else $error("mapped register refused");
    a_idle_count: assert property (acc && !pwrite && paddr[11:2] == tmc_pkg::IDX_STATUS
        && !$past(timer_running) && !$past(timer_running, 2) && !$past(timer_running, 3)
        |-> prdata[16:0] == 17'h0) else $error("stopped counter not cleared");
endmodule

bind tmc_timer16 tmc_timer16_chk tmc_timer16_chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_running(timer_running),
    .operating_mode_field(operating_mode_field));

// [tb/tb_tmc_timer16.sv]
// Purpose: Self-checking bench for the timer control block.
// Assumes: fs_tick is driven here, so source code 00 with div_alt set ticks only on demand.
// Notes:   Captured counts are compared with bit 0 masked off.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: got %0h want %0h", $time, g, e); end end
module tb_tmc_timer16;
    typedef struct packed {logic err; logic [31:0] data; logic [31:0] mask;} tmc_exp_s;
    localparam logic [11:0] A_FL = {tmc_pkg::IDX_FIRST_LO, 2'b00};
    localparam logic [11:0] A_FH = {tmc_pkg::IDX_FIRST_HI, 2'b00};
    localparam logic [11:0] A_SL = {tmc_pkg::IDX_SECOND_LO, 2'b00};
    localparam logic [11:0] A_SH = {tmc_pkg::IDX_SECOND_HI, 2'b00};
    localparam logic [11:0] A_CT = {tmc_pkg::IDX_CONTROL, 2'b00};
    localparam logic [11:0] A_SY = {tmc_pkg::IDX_SYS_CTRL, 2'b00};
    localparam logic [11:0] A_ST = {tmc_pkg::IDX_STATUS, 2'b00};
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        ext_trigger = 1'b0;
    logic        fs_tick = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        timer_running;
    logic [1:0]  operating_mode_field;
    logic [31:0] seed = 32'hb299;
    logic [15:0] first;
    logic [15:0] sec;
    logic [15:0] cnt;
    int          fail_count = 0;
    int          total_checks = 0;
    tmc_exp_s    exp_q[$];

    tmc_timer16 tmc_timer16_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_trigger(ext_trigger),
        .fs_tick(fs_tick), .timer_running(timer_running),
        .operating_mode_field(operating_mode_field));

    initial forever #12.5 pclk = ~pclk;

    function automatic logic [31:0] nxt(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Each transfer notes its expected answer before the access edge.
    task automatic xfer(input logic w, input logic e, input logic [11:0] a,
                        input logic [31:0] d, input logic [31:0] m);
        int n;
        n = 0;
        exp_q.push_back('{e, d, m});
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n == 20) begin
            fail_count++;
            wrap_up();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, 1'b0, a, d, 32'h0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b0, 1'b0, a, d, 32'hffffffff);
    endtask

    task automatic fs(input int n);
        repeat (n) begin
            @(posedge pclk);
            fs_tick <= 1'b1;
            @(posedge pclk);
            fs_tick <= 1'b0;
        end
        repeat (4) @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        tmc_exp_s x;
        if (psel && penable && pready) begin
            x = exp_q.pop_front();
            `CHK({pslverr, prdata & x.mask}, {x.err, x.data & x.mask})
        end
    end

    initial begin
        repeat (100000) @(posedge pclk);
        fail_count++;
        wrap_up();
    end

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_CT, 32'h0);
        rd(A_SY, 32'h0);
        rd(A_ST, 32'h0);
        rd(A_FL, 32'hff);
        rd(A_SH, 32'hff);
        xfer(1'b0, 1'b1, 12'hffc, 32'h0, 32'hffffffff);
        xfer(1'b1, 1'b1, 12'hffc, 32'h5, 32'h0);
        $display("reset and map test done");
        for (int i = 0; i < 16; i++) begin
            wr(A_CT, 32'(i));
            @(negedge pclk);
            `CHK(operating_mode_field, 2'(i))
            rd(A_CT, 32'(i));
        end
        $display("mode and source test done");
        seed = nxt(seed);
        first = {1'b1, seed[14:0]};
        sec = {1'b0, seed[30:16]} | 16'h2;
        wr(A_SY, 32'h1);
        wr(A_CT, 32'h0);
        wr(A_FL, {24'h0, first[7:0]});
        fs(8);
        rd(A_FL, 32'hff);
        wr(A_FH, {24'h0, first[15:8]});
        rd(A_FH, 32'hff);
        fs(8);
        rd(A_FL, {24'h0, first[7:0]});
        rd(A_FH, {24'h0, first[15:8]});
        $display("staged load test done");
        for (int m = 0; m < 4; m += 3) begin
            wr(A_CT, (m == 3) ? 32'h83 : 32'h0);
            wr(A_SL, {24'h0, sec[7:0]});
            wr(A_SH, {24'h0, sec[15:8]});
            fs(8);
            rd(A_SL, (m == 3) ? {24'h0, sec[7:0]} : 32'hff);
            rd(A_SH, (m == 3) ? {24'h0, sec[15:8]} : 32'hff);
        end
        $display("second register test done");
        wr(A_CT, 32'h40);
        wr(A_CT, 32'h50);
        repeat (4) @(posedge pclk);
        fs(40);
        rd(A_ST, 32'h00010005);
        xfer(1'b0, 1'b0, A_SL, 32'h4, 32'hfe);
        rd(A_SH, 32'h0);
        wr(A_SY, 32'h5);
        // The run state drops one edge after the start field is cleared.
        @(posedge pclk);
        @(negedge pclk);
        `CHK(timer_running, 1'b0)
        rd(A_CT, 32'h40);
        wr(A_SY, 32'h1);
        rd(A_ST, 32'h0);
        $display("capture and stop test done");
        for (int k = 2; k < 4; k++) begin
            wr(A_CT, 32'h40 | 32'(k << 4));
            @(negedge pclk);
            `CHK(timer_running, 1'b0)
            @(posedge pclk);
            ext_trigger <= (k == 2);
            repeat (4) @(posedge pclk);
            @(negedge pclk);
            `CHK(timer_running, 1'b1)
            wr(A_CT, 32'h40);
        end
        $display("edge start test done");
        wr(A_CT, 32'h08);
        wr(A_CT, 32'h18);
        repeat (4) @(posedge pclk);
        xfer(1'b0, 1'b0, A_ST, 32'h0, 32'h0);
        cnt = prdata[15:0];
        // Read setups 64 cycles apart see exactly eight fast ticks.
        repeat (61) @(posedge pclk);
        rd(A_ST, {16'h0001, cnt + 16'h0008});
        $display("fast source test done");
        wrap_up();
    end
endmodule
